// ==== hw/omc_map.svh ====
`ifndef OMC_MAP_SVH
`define OMC_MAP_SVH

// Clock and timing
`define OMC_CLK_MHZ         25
`define OMC_RESET_MIN_NS    1000
`define OMC_INIT_NS         100000
// Least pulse rounds up, longest interval rounds down
`define OMC_RESET_MIN_CYC   ((`OMC_RESET_MIN_NS * `OMC_CLK_MHZ + 999) / 1000)
`define OMC_INIT_CYC        ((`OMC_INIT_NS * `OMC_CLK_MHZ) / 1000)

// Serial port
`define OMC_DEV_ADDR        7'h50
`define OMC_BYTE_BITS       4'h8

// Lower page byte addresses
`define OMC_ADDR_STATUS     8'h02
`define OMC_ADDR_FLAGS      8'h03
`define OMC_ADDR_CTRL       8'h56
`define OMC_ADDR_PAGE       8'h7f

// Field positions
`define OMC_STAT_NOT_READY  0
`define OMC_STAT_LOW_POWER  1
`define OMC_FLAG_INIT_DONE  0
`define OMC_FLAG_LANE_LSB   1
`define OMC_CTRL_FORCE_LP   0

// Reset values
`define OMC_CTRL_RESET      8'h00
`define OMC_SYNC_RESET      9'h00f

`endif

// ==== hw/omc_pkg.sv ====
package omc_pkg;

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_ADDR   = 3'b001,
		S_WORD   = 3'b010,
		S_WDATA  = 3'b011,
		S_RDATA  = 3'b100,
		S_ACK_TX = 3'b101,
		S_ACK_RX = 3'b110,
		S_WAIT   = 3'b111
	} omc_bus_state_type;

	typedef logic [7:0] omc_byte_type;

endpackage : omc_pkg

// ==== hw/omc_sync.sv ====
`timescale 1ns/1ps
module omc_sync #(
	parameter int            W         = 1,
	parameter logic [W-1:0]  RESET_VAL = '0
) (
	input  wire logic         clk_i,     // Sampling clock
	input  wire logic         rst_n_i,   // Async reset, active low
	input  wire logic [W-1:0] d_i,       // Asynchronous inputs
	output logic      [W-1:0] q_o        // Synchronised outputs
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end
		else
		begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;

endmodule : omc_sync

// ==== hw/omc_byte_ram.sv ====
`timescale 1ns/1ps
module omc_byte_ram #(
	parameter int AW = 10,
	parameter int DW = 8
) (
	input  wire logic          clk_i,    // Clock
	input  wire logic          we_i,     // Write strobe
	input  wire logic [AW-1:0] waddr_i,  // Write index
	input  wire logic [DW-1:0] wdata_i,  // Write data
	input  wire logic [AW-1:0] raddr_i,  // Read index
	output logic      [DW-1:0] rdata_o   // Registered read data
);

	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [DW-1:0] rdata_q;

	always_ff @(posedge clk_i)
	begin
		if (we_i)
			mem[waddr_i] <= wdata_i;
		rdata_q <= mem[raddr_i];
	end

	assign rdata_o = rdata_q;

endmodule : omc_byte_ram

// ==== hw/omc_mgmt.sv ====
`timescale 1ns/1ps
`include "omc_map.svh"

module omc_mgmt
	import omc_pkg::*;
#(
	parameter int LANES         = 4,
	parameter int PAGE_W        = 2,
	parameter int RESET_MIN_CYC = `OMC_RESET_MIN_CYC,
	parameter int INIT_CYC      = `OMC_INIT_CYC
) (
	input  wire logic             core_clk_i,           // System clock
	input  wire logic             reset_n_i,            // Async reset, active low
	input  wire logic             module_select_n_i,    // Select pin, active low
	input  wire logic             module_reset_n_i,     // Reset pin, active low
	input  wire logic             low_power_request_i,  // Low-power request pin
	input  wire logic [LANES-1:0] lane_fault_i,         // Lane fault levels
	input  wire logic             scl_i,                // Serial clock pin
	input  wire logic             sda_i,                // Serial data pin in
	output logic                  sda_o,                // Serial data out, always low
	output logic                  sda_oe_o,             // Serial data drive enable
	output logic                  interrupt_out_n_o,    // Interrupt out, always low
	output logic                  interrupt_out_oe_o,   // Interrupt pull-down enable
	output logic                  module_present_n_o,   // Presence, low when plugged
	output logic                  low_power_mode_o      // Reduced-power state
);

	localparam int FW = LANES + 1;
	localparam int AW = PAGE_W + 8;
	localparam int LW = $clog2(RESET_MIN_CYC + 1);
	localparam int IW = $clog2(INIT_CYC + 1);
	localparam int SW = LANES + 5;

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers and edge detection

	logic [SW-1:0]    sync_s;
	logic             scl_s;
	logic             sda_s;
	logic             sel_n_s;
	logic             rst_pin_s;
	logic             lp_req_s;
	logic [LANES-1:0] fault_s;

	omc_sync #(
		.W         (SW),
		.RESET_VAL (SW'(`OMC_SYNC_RESET))
	) u_sync (
		.clk_i   (core_clk_i),
		.rst_n_i (reset_n_i),
		.d_i     ({lane_fault_i, low_power_request_i, module_reset_n_i,
		           module_select_n_i, sda_i, scl_i}),
		.q_o     (sync_s)
	);

	assign {fault_s, lp_req_s, rst_pin_s, sel_n_s, sda_s, scl_s} = sync_s;

	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic selected;

	assign scl_rise  = scl_s & ~scl_prev_q;
	assign scl_fall  = ~scl_s & scl_prev_q;
	assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	assign selected  = ~sel_n_s;

	////////////////////////////////////////////////////////////////////////////
	// Memory index mapping

	function automatic logic [AW-1:0] map_index(input logic [7:0] addr,
	                                            input logic [PAGE_W-1:0] page);
		logic [PAGE_W-1:0] eff;
		eff = addr[7] ? page : '0;
		return {eff, addr};
	endfunction : map_index

	////////////////////////////////////////////////////////////////////////////
	// Reset, initialization, flags and sideband state

	logic             rst_prev_q,  rst_prev_d;
	logic [LW-1:0]    low_cnt_q,   low_cnt_d;
	logic             not_ready_q, not_ready_d;
	logic [IW-1:0]    init_cnt_q,  init_cnt_d;
	logic [FW-1:0]    flags_q,     flags_d;
	logic [LANES-1:0] fault_prev_q, fault_prev_d;
	logic             intr_oe_q,   intr_oe_d;
	logic             lp_mode_q,   lp_mode_d;
	logic             soft_rst;
	logic             init_done;
	logic [FW-1:0]    flag_set;
	logic [FW-1:0]    flag_clr;
	logic [7:0]       ctrl_q,      ctrl_d;

	assign soft_rst  = rst_pin_s & ~rst_prev_q
	                 & (low_cnt_q >= LW'(RESET_MIN_CYC));
	assign init_done = not_ready_q & ~soft_rst & (init_cnt_q == IW'(INIT_CYC - 1));
	assign flag_set  = {(fault_s & ~fault_prev_q), init_done};

	always_comb
	begin
		rst_prev_d   = rst_pin_s;
		fault_prev_d = fault_s;
		low_cnt_d    = low_cnt_q;
		not_ready_d  = not_ready_q;
		init_cnt_d   = init_cnt_q;
		if (!rst_pin_s)
		begin
			if (low_cnt_q < LW'(RESET_MIN_CYC))
				low_cnt_d = low_cnt_q + LW'(1);
		end
		else
			low_cnt_d = '0;
		if (soft_rst)
		begin
			not_ready_d = 1'b1;
			init_cnt_d  = '0;
		end
		else if (init_done)
			not_ready_d = 1'b0;
		else if (not_ready_q)
			init_cnt_d = init_cnt_q + IW'(1);
		// Set wins over a read clear in the same cycle
		flags_d   = (soft_rst ? '0 : (flags_q & ~flag_clr)) | flag_set;
		intr_oe_d = |flags_q;
		lp_mode_d = lp_req_s | ctrl_q[`OMC_CTRL_FORCE_LP];
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_prev_q   <= 1'b1;
			fault_prev_q <= '0;
			low_cnt_q    <= '0;
			not_ready_q  <= 1'b1;
			init_cnt_q   <= '0;
			flags_q      <= '0;
			intr_oe_q    <= 1'b0;
			lp_mode_q    <= 1'b0;
		end
		else
		begin
			rst_prev_q   <= rst_prev_d;
			fault_prev_q <= fault_prev_d;
			low_cnt_q    <= low_cnt_d;
			not_ready_q  <= not_ready_d;
			init_cnt_q   <= init_cnt_d;
			flags_q      <= flags_d;
			intr_oe_q    <= intr_oe_d;
			lp_mode_q    <= lp_mode_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Two-wire serial slave

	omc_bus_state_type  state_q,  state_d;
	logic [3:0]         bit_cnt_q, bit_cnt_d;
	logic [7:0]         rx_q,     rx_d;
	logic [7:0]         tx_q,     tx_d;
	logic [7:0]         ptr_q,    ptr_d;
	logic               rw_q,     rw_d;
	logic               have_word_q, have_word_d;
	logic               drive_q,  drive_d;
	logic [PAGE_W-1:0]  page_q,   page_d;
	logic               ram_we;
	logic [AW-1:0]      rd_index;
	logic [7:0]         ram_rdata;
	logic [7:0]         rd_byte;
	logic [7:0]         status_byte;

	assign rd_index    = map_index(ptr_q, page_q);
	assign status_byte = {6'h00, lp_mode_q, not_ready_q};

	omc_byte_ram #(
		.AW (AW),
		.DW (8)
	) u_ram (
		.clk_i   (core_clk_i),
		.we_i    (ram_we),
		.waddr_i (map_index(ptr_q, page_q)),
		.wdata_i (rx_q),
		.raddr_i (rd_index),
		.rdata_o (ram_rdata)
	);

	always_comb
	begin
		unique case (ptr_q)
			`OMC_ADDR_STATUS: rd_byte = status_byte;
			`OMC_ADDR_FLAGS:  rd_byte = {{(8-FW){1'b0}}, flags_q};
			`OMC_ADDR_CTRL:   rd_byte = ctrl_q;
			`OMC_ADDR_PAGE:   rd_byte = {{(8-PAGE_W){1'b0}}, page_q};
			default:          rd_byte = ram_rdata;
		endcase
	end

	always_comb
	begin
		state_d     = state_q;
		bit_cnt_d   = bit_cnt_q;
		rx_d        = rx_q;
		tx_d        = tx_q;
		ptr_d       = ptr_q;
		rw_d        = rw_q;
		have_word_d = have_word_q;
		drive_d     = drive_q;
		page_d      = page_q;
		ctrl_d      = ctrl_q;
		ram_we      = 1'b0;
		flag_clr    = '0;
		if (!selected)
		begin
			state_d = S_IDLE;
			drive_d = 1'b0;
		end
		else if (bus_start)
		begin
			state_d     = S_ADDR;
			bit_cnt_d   = '0;
			have_word_d = 1'b0;
			drive_d     = 1'b0;
		end
		else if (bus_stop)
		begin
			state_d = S_IDLE;
			drive_d = 1'b0;
		end
		else
		begin
			unique case (state_q)
				S_IDLE, S_WAIT:
					drive_d = 1'b0;
				S_ADDR, S_WORD, S_WDATA:
				begin
					if (scl_rise)
					begin
						rx_d      = {rx_q[6:0], sda_s};
						bit_cnt_d = bit_cnt_q + 4'h1;
					end
					if (scl_fall && bit_cnt_q == `OMC_BYTE_BITS)
					begin
						bit_cnt_d = '0;
						state_d   = S_ACK_TX;
						drive_d   = 1'b1;
						if (state_q == S_ADDR)
						begin
							rw_d = rx_q[0];
							if (rx_q[7:1] != `OMC_DEV_ADDR)
							begin
								state_d = S_WAIT;
								drive_d = 1'b0;
							end
						end
						else if (state_q == S_WORD)
						begin
							ptr_d       = rx_q;
							have_word_d = 1'b1;
						end
						else
						begin
							ptr_d = ptr_q + 8'h01;
							unique case (ptr_q)
								`OMC_ADDR_PAGE: page_d = rx_q[PAGE_W-1:0];
								`OMC_ADDR_CTRL: ctrl_d = rx_q;
								`OMC_ADDR_STATUS, `OMC_ADDR_FLAGS: ;
								default:        ram_we = 1'b1;
							endcase
						end
					end
				end
				S_ACK_TX:
					if (scl_fall)
					begin
						if (rw_q)
						begin
							state_d = S_RDATA;
							tx_d    = rd_byte;
							drive_d = ~rd_byte[7];
							if (ptr_q == `OMC_ADDR_FLAGS)
								flag_clr = flags_q;
						end
						else
						begin
							state_d = have_word_q ? S_WDATA : S_WORD;
							drive_d = 1'b0;
						end
					end
				S_RDATA:
				begin
					if (scl_rise)
						bit_cnt_d = bit_cnt_q + 4'h1;
					if (scl_fall)
					begin
						if (bit_cnt_q == `OMC_BYTE_BITS)
						begin
							bit_cnt_d = '0;
							state_d   = S_ACK_RX;
							drive_d   = 1'b0;
						end
						else
						begin
							tx_d    = {tx_q[6:0], 1'b0};
							drive_d = ~tx_q[6];
						end
					end
				end
				S_ACK_RX:
				begin
					if (scl_rise)
					begin
						if (sda_s)
							state_d = S_WAIT;
						else
							ptr_d = ptr_q + 8'h01;
					end
					else if (scl_fall)
					begin
						state_d = S_RDATA;
						tx_d    = rd_byte;
						drive_d = ~rd_byte[7];
						if (ptr_q == `OMC_ADDR_FLAGS)
							flag_clr = flags_q;
					end
				end
			endcase
		end
		if (soft_rst)
		begin
			page_d = '0;
			ctrl_d = `OMC_CTRL_RESET;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			scl_prev_q  <= 1'b1;
			sda_prev_q  <= 1'b1;
			state_q     <= S_IDLE;
			bit_cnt_q   <= '0;
			rx_q        <= '0;
			tx_q        <= '0;
			ptr_q       <= '0;
			rw_q        <= 1'b0;
			have_word_q <= 1'b0;
			drive_q     <= 1'b0;
			page_q      <= '0;
			ctrl_q      <= `OMC_CTRL_RESET;
		end
		else
		begin
			scl_prev_q  <= scl_s;
			sda_prev_q  <= sda_s;
			state_q     <= state_d;
			bit_cnt_q   <= bit_cnt_d;
			rx_q        <= rx_d;
			tx_q        <= tx_d;
			ptr_q       <= ptr_d;
			rw_q        <= rw_d;
			have_word_q <= have_word_d;
			drive_q     <= drive_d;
			page_q      <= page_d;
			ctrl_q      <= ctrl_d;
		end
	end

	// Pins that only pull low, then the low-power mode output
	assign sda_o              = 1'b0;
	assign sda_oe_o           = drive_q;
	assign interrupt_out_n_o  = 1'b0;
	assign interrupt_out_oe_o = intr_oe_q;
	assign module_present_n_o = 1'b0;
	assign low_power_mode_o   = lp_mode_q;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);

	a_desel_no_drive: assert property (sel_n_s |=> !drive_q && state_q == S_IDLE)
		else $error("drive while deselected");
	a_addr_ack: assert property (selected && !bus_start && !bus_stop && state_q == S_ADDR
		&& scl_fall && bit_cnt_q == `OMC_BYTE_BITS && rx_q[7:1] == `OMC_DEV_ADDR
		|=> drive_q && state_q == S_ACK_TX)
		else $error("own address not acknowledged");
	a_addr_reject: assert property (selected && !bus_start && !bus_stop && state_q == S_ADDR
		&& scl_fall && bit_cnt_q == `OMC_BYTE_BITS && rx_q[7:1] != `OMC_DEV_ADDR
		|=> !drive_q && state_q == S_WAIT)
		else $error("foreign address answered");
	a_intr_tracks: assert property (##1 intr_oe_q == |$past(flags_q))
		else $error("interrupt does not follow flags");
	a_flag_sticky: assert property (flags_q[0] && flag_clr == '0 && !soft_rst |=> flags_q[0])
		else $error("flag lost without read");
	a_done_with_flag: assert property ($fell(not_ready_q) |-> flags_q[0] ##1 intr_oe_q)
		else $error("completion without interrupt");
	a_init_start: assert property ($rose(rst_pin_s) && low_cnt_q >= LW'(RESET_MIN_CYC)
		|=> not_ready_q && init_cnt_q == '0)
		else $error("init not started at reset rise");
	a_reset_defaults: assert property (soft_rst |=> page_q == '0 && ctrl_q == `OMC_CTRL_RESET
		&& not_ready_q && init_cnt_q == '0)
		else $error("settings not restored");
	a_lowpower: assert property (lp_req_s |=> low_power_mode_o)
		else $error("low-power request ignored");
	a_pins_low_only: assert property (!interrupt_out_n_o && !sda_o && !module_present_n_o)
		else $error("pin driven high");
	a_lower_fixed: assert property (!ptr_q[7] |-> rd_index[AW-1:8] == '0)
		else $error("lower page moved with page select");

	c_flag_read: cover property (state_q == S_ACK_RX && ptr_q == `OMC_ADDR_FLAGS);
	c_page_write: cover property ($changed(page_q) && !soft_rst);
	c_soft_reset: cover property (soft_rst);
	c_init_done: cover property (init_done);

endmodule : omc_mgmt

// ==== test/omc_host_model.sv ====
`timescale 1ns/1ps
module omc_host_model (
	output logic      scl_o,    // Serial clock, idles high
	output logic      sda_oe_o, // High while host pulls data low
	input  wire logic sda_i     // Resolved data line
);
	localparam time QTR = 80ns;

	logic slow;

	initial
	begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
		slow = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Also serves as repeated start
	task automatic start_cond();
		#QTR sda_oe_o = 1'b0;
		#QTR scl_o = 1'b1;
		#QTR sda_oe_o = 1'b1;
		#QTR scl_o = 1'b0;
	endtask : start_cond

	task automatic stop_cond();
		#QTR sda_oe_o = 1'b1;
		#QTR scl_o = 1'b1;
		#QTR sda_oe_o = 1'b0;
		#QTR;
	endtask : stop_cond

	// Slow mode stretches the low phase
	task automatic bit_xfer(input logic b, output logic r);
		#QTR sda_oe_o = ~b;
		if (slow)
			#(4 * QTR);
		#QTR scl_o = 1'b1;
		#QTR r = sda_i;
		#QTR scl_o = 1'b0;
	endtask : bit_xfer

	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_xfer(b[i], r);
		bit_xfer(1'b1, r);
		ack = ~r;
	endtask : put_byte

	// Last byte answered with a release, ending the read
	task automatic get_byte(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_xfer(1'b1, b[i]);
		bit_xfer(last, r);
	endtask : get_byte
endmodule : omc_host_model

// ==== test/tb_omc_mgmt.sv ====
`timescale 1ns/1ps
`include "omc_map.svh"
module tb_omc_mgmt;
	localparam int RST_MIN = 4;
	localparam int INIT    = 20;
	localparam int LIMIT   = 40000;

	logic       core_clk;
	logic       reset_n;
	logic       sel_n;
	logic       mrst_n;
	logic       lp_req;
	logic [3:0] fault;
	logic       scl;
	logic       host_oe;
	logic       sda_out;
	logic       sda_oe;
	logic       int_n;
	logic       int_oe;
	logic       present_n;
	logic       lp_mode;
	wire        sda_w;
	wire        int_w;
	int         fail_count;
	int         num_checks;
	int         cycles;
	int         lane;
	logic       ok;
	logic [7:0] v;
	logic [7:0] mem [4];
	logic [7:0] addrs [4] = '{8'h00, 8'h04, 8'h55, 8'h7e};

	assign sda_w = ~host_oe & (sda_oe ? sda_out : 1'b1);
	assign int_w = int_oe ? int_n : 1'b1;

	omc_mgmt #(.RESET_MIN_CYC(RST_MIN), .INIT_CYC(INIT)) i_dut (
		.core_clk_i         (core_clk),
		.reset_n_i          (reset_n),
		.module_select_n_i  (sel_n),
		.module_reset_n_i   (mrst_n),
		.low_power_request_i(lp_req),
		.lane_fault_i       (fault),
		.scl_i              (scl),
		.sda_i              (sda_w),
		.sda_o              (sda_out),
		.sda_oe_o           (sda_oe),
		.interrupt_out_n_o  (int_n),
		.interrupt_out_oe_o (int_oe),
		.module_present_n_o (present_n),
		.low_power_mode_o   (lp_mode)
	);

	omc_host_model i_host (
		.scl_o   (scl),
		.sda_oe_o(host_oe),
		.sda_i   (sda_w)
	);

	initial
		core_clk = 1'b0;
	always #20 core_clk = ~core_clk;

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			fail_count++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] status_exp(input logic lp, input logic nr);
		status_exp = (8'(lp) << `OMC_STAT_LOW_POWER) | (8'(nr) << `OMC_STAT_NOT_READY);
	endfunction : status_exp

	function automatic logic [7:0] flags_exp(input logic [3:0] lanes, input logic done);
		flags_exp = (8'(lanes) << `OMC_FLAG_LANE_LSB) | (8'(done) << `OMC_FLAG_INIT_DONE);
	endfunction : flags_exp

	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check_byte

	task automatic check_level(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask : check_level

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic exp);
		logic k0, k1, k2;
		@(negedge core_clk);
		i_host.start_cond();
		i_host.put_byte({`OMC_DEV_ADDR, 1'b0}, k0);
		i_host.put_byte(a, k1);
		i_host.put_byte(d, k2);
		i_host.stop_cond();
		check_level("write acks", exp, k0 & k1 & k2);
	endtask : wr

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic       k0, k1, k2;
		logic [7:0] d;
		@(negedge core_clk);
		i_host.start_cond();
		i_host.put_byte({`OMC_DEV_ADDR, 1'b0}, k0);
		i_host.put_byte(a, k1);
		i_host.start_cond();
		i_host.put_byte({`OMC_DEV_ADDR, 1'b1}, k2);
		i_host.get_byte(1'b1, d);
		i_host.stop_cond();
		check_level({what, " acks"}, 1'b1, k0 & k1 & k2);
		check_byte(what, exp, d);
	endtask : rd_chk

	// Cycles from release to the completion interrupt
	task automatic wait_int();
		int n;
		n = 0;
		while (int_oe !== 1'b1 && n < INIT + 10)
		begin
			@(posedge core_clk);
			n++;
		end
		check_level("completion delay", 1'b1, 1'(n >= INIT && n <= INIT + 6));
	endtask : wait_int

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		reset_n = 1'b0;
		sel_n = 1'b1;
		mrst_n = 1'b1;
		lp_req = 1'b0;
		fault = 4'h0;
		void'($urandom(19));
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		wait_int();
		check_level("present", 1'b0, present_n);
		check_level("interrupt pin", 1'b0, int_w);
		check_level("data pin value", 1'b0, sda_out);
		sel_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		rd_chk("status", `OMC_ADDR_STATUS, status_exp(1'b0, 1'b0));
		rd_chk("flags", `OMC_ADDR_FLAGS, flags_exp(4'h0, 1'b1));
		repeat (4) @(posedge core_clk);
		check_level("interrupt cleared", 1'b0, int_oe);
		lane = $urandom_range(3, 0);
		fault <= 4'(1 << lane);
		repeat (8) @(posedge core_clk);
		check_level("fault interrupt", 1'b0, int_w);
		fault <= 4'h0;
		rd_chk("lane flags", `OMC_ADDR_FLAGS, flags_exp(4'(1 << lane), 1'b0));
		rd_chk("flags after read", `OMC_ADDR_FLAGS, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			v = 8'($urandom);
			wr(addrs[i], v, 1'b1);
			rd_chk("lower page", addrs[i], v);
		end
		for (int p = 3; p >= 0; p--)
		begin
			mem[p] = 8'($urandom);
			wr(`OMC_ADDR_PAGE, 8'(p), 1'b1);
			wr(8'hff, mem[p], 1'b1);
		end
		i_host.slow = 1'b1;
		for (int p = 0; p < 4; p++)
		begin
			wr(`OMC_ADDR_PAGE, 8'(p), 1'b1);
			rd_chk("page select", `OMC_ADDR_PAGE, 8'(p));
			rd_chk("upper page", 8'hff, mem[p]);
		end
		i_host.slow = 1'b0;
		@(posedge core_clk);
		lp_req <= 1'b1;
		repeat (6) @(posedge core_clk);
		check_level("low power", 1'b1, lp_mode);
		rd_chk("status lp", `OMC_ADDR_STATUS, status_exp(1'b1, 1'b0));
		@(posedge core_clk);
		lp_req <= 1'b0;
		wr(`OMC_ADDR_CTRL, 8'h01, 1'b1);
		rd_chk("status forced lp", `OMC_ADDR_STATUS, status_exp(1'b1, 1'b0));
		wr(8'h55, 8'h3c, 1'b1);
		@(posedge core_clk);
		sel_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		wr(8'h55, 8'hc3, 1'b0);
		@(posedge core_clk);
		sel_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		i_host.start_cond();
		i_host.put_byte(8'ha2, ok);
		i_host.stop_cond();
		check_level("foreign address ack", 1'b0, ok);
		rd_chk("deselected write", 8'h55, 8'h3c);
		// Two-byte read, host acknowledges the first byte
		@(negedge core_clk);
		i_host.start_cond();
		i_host.put_byte({`OMC_DEV_ADDR, 1'b0}, ok);
		i_host.put_byte(8'h55, ok);
		i_host.start_cond();
		i_host.put_byte({`OMC_DEV_ADDR, 1'b1}, ok);
		i_host.get_byte(1'b0, v);
		check_byte("sequential first", 8'h3c, v);
		i_host.get_byte(1'b1, v);
		i_host.stop_cond();
		check_byte("sequential next", 8'h01, v);
		@(posedge core_clk);
		mrst_n <= 1'b0;
		repeat (RST_MIN - 2) @(posedge core_clk);
		mrst_n <= 1'b1;
		repeat (40) @(posedge core_clk);
		check_level("short pulse ignored", 1'b0, int_oe);
		rd_chk("ctrl kept", `OMC_ADDR_CTRL, 8'h01);
		@(posedge core_clk);
		mrst_n <= 1'b0;
		repeat (3 * INIT) @(posedge core_clk);
		mrst_n <= 1'b1;
		wait_int();
		check_level("low power restored", 1'b0, lp_mode);
		rd_chk("ctrl default", `OMC_ADDR_CTRL, `OMC_CTRL_RESET);
		rd_chk("page default", `OMC_ADDR_PAGE, 8'h00);
		rd_chk("status ready", `OMC_ADDR_STATUS, status_exp(1'b0, 1'b0));
		conclude();
	end
endmodule : tb_omc_mgmt
